/* File: logic/nvm_cmd_pkg.sv */
// nvm_cmd_pkg: constants, register map and state encodings of the
// nonvolatile command controller.
// assumes the controller top and the testbench are its only users; nothing is imported.
// What this block does
// - chip erase clears flash and eeprom to ones; eeprom spared when keep fuse set
// - chip erase ignores boot lock and application write guard
// - eeprom erase sets all eeprom bits and halts cpu until done
// - fuse write starts only from the one-wire programming port
// - fuses read by plain memory reads, no command needed
// - reset during a write aborts that write
// - eeprom ready flag set when eeprom free; irq while flag and enable
// - sleep only without ongoing write, else keep array and clock running
// - eeprom ready interrupt wakes from idle sleep only
// - page buffer cleared on every wake-up
// - command write needs guard key within the preceding four instructions
// - command codes: none, write, erase, erase-write, buffer clear, chip erase, eeprom erase, fuse write
// - with boot lock in force boot reads and fetches return zero
// - boot lock written only from boot code, cleared only by reset
// - boot lock effective when execution first leaves boot section
// - application write guard is set-only, blocks app code writes
// - write error flag reports failure of the most recent operation
// - eeprom and flash busy flags read one while executing, read-only
// - eeprom ready flag stays set while eeprom idle, write one clears
// - buffer clear sets buffer to ones and halts cpu seven cycles
package nvm_cmd_pkg;
  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_CMD = 4'h0;
  localparam logic [3:0] IDX_LOCK = 4'h1;
  localparam logic [3:0] IDX_STATUS = 4'h2;
  localparam logic [3:0] IDX_INTEN = 4'h3;
  localparam logic [3:0] IDX_INTFLAG = 4'h4;
  localparam logic [3:0] IDX_DATA = 4'h6;
  localparam logic [3:0] IDX_ADDR = 4'h8;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_APP_GUARD = 0;
  localparam int BIT_BOOT_LOCK = 1;
  localparam int BIT_FLASH_BUSY = 0;
  localparam int BIT_EE_BUSY = 1;
  localparam int BIT_WR_ERR = 2;
  localparam int BIT_EE_READY = 0;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_PAGE_WRITE = 3'h1;
  localparam logic [2:0] CMD_PAGE_ERASE = 3'h2;
  localparam logic [2:0] CMD_ERASE_WRITE = 3'h3;
  localparam logic [2:0] CMD_BUF_CLEAR = 3'h4;
  localparam logic [2:0] CMD_FULL_ERASE = 3'h5;
  localparam logic [2:0] CMD_EE_ERASE = 3'h6;
  localparam logic [2:0] CMD_FUSE_PROG = 3'h7;
  // ----------------------------------------------------------------
  // target sections, sleep modes, reset values, timing
  // ----------------------------------------------------------------
  localparam logic [1:0] SECT_BOOT = 2'h0;
  localparam logic [1:0] SECT_APPCODE = 2'h1;
  localparam logic [1:0] SECT_APPDATA = 2'h2;
  localparam logic [1:0] SECT_EEPROM = 2'h3;
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] GUARD_WINDOW = 3'h4;
  localparam logic [15:0] BUF_CLEAR_CYCLES = 16'h0007;
  typedef enum logic [2:0] {
    SL_RUN = 3'b001,
    SL_HOLD = 3'b010,
    SL_SLEEP = 3'b100
  } sleep_e;
endpackage

/* File: logic/nvm_command_controller.sv */
// nvm_command_controller: command decode, protection bits, status,
// ready interrupt and sleep handling of the nonvolatile controller.
// assumes an apb master, a section decoder and array timing outside.
`timescale 1ns/1ns
module nvm_command_controller #(
  parameter int FLASH_OP_CYCLES = 64,
  parameter int EE_OP_CYCLES = 32,
  parameter int EE_ERASE_CYCLES = 128,
  parameter int FULL_ERASE_CYCLES = 256,
  parameter int FUSE_CYCLES = 16
) (
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [5:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_PROG_PORT_ACCESS,
  input wire logic I_GUARD_KEY_WRITE,
  input wire logic I_INSTR_STEP,
  input wire logic I_EXEC_IN_BOOT,
  input wire logic [1:0] I_TARGET_SECT,
  input wire logic I_BUF_MIXED,
  input wire logic I_BUF_LOAD,
  input wire logic [15:0] I_BUF_LOAD_ADDR,
  input wire logic I_EEPROM_KEEP_FUSE,
  input wire logic I_SLEEP_REQ,
  input wire logic [1:0] I_SLEEP_MODE,
  output logic O_ARRAY_RUN,
  output logic [2:0] O_ARRAY_CMD,
  output logic O_ARRAY_EEPROM,
  output logic O_ERASE_FLASH_ALL,
  output logic O_ERASE_EEPROM_ALL,
  output logic O_FUSE_WRITE,
  output logic [15:0] O_FUSE_ADDR,
  output logic [15:0] O_FUSE_DATA,
  output logic O_BUF_CLEAR,
  output logic O_CPU_HALT,
  output logic O_BOOT_HIDE,
  output logic O_IRQ,
  output logic O_WAKE_REQ,
  output logic O_NVM_ASLEEP,
  output logic O_CLOCK_KEEP
);
  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (FLASH_OP_CYCLES < 1 || FLASH_OP_CYCLES > 65535 || EE_OP_CYCLES < 1 || EE_OP_CYCLES > 65535 ||
      EE_ERASE_CYCLES < 1 || EE_ERASE_CYCLES > 65535 || FULL_ERASE_CYCLES < 1 ||
      FULL_ERASE_CYCLES > 65535 || FUSE_CYCLES < 1 || FUSE_CYCLES > 65535) begin : g_bad
    $error("operation cycle counts must lie in 1..65535");
  end

  localparam logic [15:0] FLASH_N = 16'(FLASH_OP_CYCLES);
  localparam logic [15:0] EE_N = 16'(EE_OP_CYCLES);
  localparam logic [15:0] EE_ERASE_N = 16'(EE_ERASE_CYCLES);
  localparam logic [15:0] FULL_N = 16'(FULL_ERASE_CYCLES);
  localparam logic [15:0] FUSE_N = 16'(FUSE_CYCLES);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] cmd;
    logic boot_lock;
    logic boot_pend;
    logic app_guard;
    logic wr_err;
    logic ie;
    logic ready_flag;
    logic [15:0] fdata;
    logic [15:0] taddr;
    logic [2:0] guard_cnt;
    logic [15:0] op_left;
    logic [2:0] op_code;
    logic flash_busy;
    logic ee_busy;
    logic halt;
    logic run;
    logic erase_flash;
    logic erase_ee;
    logic fuse_wr;
    logic to_ee;
    logic buf_clr;
    logic [31:0] prdata;
    logic slverr;
    nvm_cmd_pkg::sleep_e sleep;
  } state_s;

  state_s cur;
  state_s next_cur;

  // register index of an apb address; misaligned yields an unmapped index
  function automatic logic [3:0] reg_index(input logic [5:0] a);
    reg_index = (a[1:0] == 2'b00) ? a[5:2] : 4'hf;
  endfunction

  function automatic logic mapped(input logic [3:0] i);
    mapped = (i <= nvm_cmd_pkg::IDX_INTFLAG) || (i == nvm_cmd_pkg::IDX_DATA) ||
             (i == nvm_cmd_pkg::IDX_ADDR);
  endfunction

  logic [3:0] idx;
  logic wr_acc;
  logic setup;
  logic busy_any;
  logic guard_open;

  assign idx = reg_index(I_PADDR);
  assign setup = I_PSEL && !I_PENABLE;
  assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE && mapped(idx);
  assign busy_any = cur.flash_busy || cur.ee_busy || cur.halt;
  assign guard_open = cur.guard_cnt != 3'h0;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.buf_clr = 1'b0;

    // apb read data captured in setup so the access phase needs no wait
    if (setup) begin
      next_cur.prdata = 32'h0000_0000;
      next_cur.slverr = !mapped(idx);
      case (idx)
        nvm_cmd_pkg::IDX_CMD: next_cur.prdata[2:0] = cur.cmd;
        nvm_cmd_pkg::IDX_LOCK: begin
          next_cur.prdata[nvm_cmd_pkg::BIT_BOOT_LOCK] = cur.boot_lock || cur.boot_pend;
          next_cur.prdata[nvm_cmd_pkg::BIT_APP_GUARD] = cur.app_guard;
        end
        nvm_cmd_pkg::IDX_STATUS: begin
          next_cur.prdata[nvm_cmd_pkg::BIT_WR_ERR] = cur.wr_err;
          next_cur.prdata[nvm_cmd_pkg::BIT_EE_BUSY] = cur.ee_busy;
          next_cur.prdata[nvm_cmd_pkg::BIT_FLASH_BUSY] = cur.flash_busy;
        end
        nvm_cmd_pkg::IDX_INTEN: next_cur.prdata[nvm_cmd_pkg::BIT_EE_READY] = cur.ie;
        nvm_cmd_pkg::IDX_INTFLAG: next_cur.prdata[nvm_cmd_pkg::BIT_EE_READY] = cur.ready_flag;
        nvm_cmd_pkg::IDX_DATA: next_cur.prdata[15:0] = cur.fdata;
        nvm_cmd_pkg::IDX_ADDR: next_cur.prdata[15:0] = cur.taddr;
        default: next_cur.prdata = 32'h0000_0000;
      endcase
    end

    // guard window: key opens four instructions, each step closes one
    if (I_GUARD_KEY_WRITE) begin
      next_cur.guard_cnt = nvm_cmd_pkg::GUARD_WINDOW;
    end else if (I_INSTR_STEP && guard_open) begin
      next_cur.guard_cnt = cur.guard_cnt - 3'h1;
    end

    // address register follows the last page buffer location touched
    if (I_BUF_LOAD) begin
      next_cur.taddr = I_BUF_LOAD_ADDR;
    end

    // plain register writes
    if (wr_acc) begin
      case (idx)
        nvm_cmd_pkg::IDX_LOCK: begin
          if (I_PWDATA[nvm_cmd_pkg::BIT_APP_GUARD]) begin
            next_cur.app_guard = 1'b1;
          end
          if (I_PWDATA[nvm_cmd_pkg::BIT_BOOT_LOCK] && I_EXEC_IN_BOOT && !cur.boot_lock) begin
            next_cur.boot_pend = 1'b1;
          end
        end
        nvm_cmd_pkg::IDX_INTEN: next_cur.ie = I_PWDATA[nvm_cmd_pkg::BIT_EE_READY];
        nvm_cmd_pkg::IDX_DATA: next_cur.fdata = I_PWDATA[15:0];
        nvm_cmd_pkg::IDX_ADDR: next_cur.taddr = I_PWDATA[15:0];
        default: ;
      endcase
    end

    // pending boot lock bites once execution leaves the boot section
    if (cur.boot_pend && !I_EXEC_IN_BOOT) begin
      next_cur.boot_lock = 1'b1;
      next_cur.boot_pend = 1'b0;
    end

    // running operation counts down; end releases halt and busy
    if (cur.run) begin
      if (cur.op_left == 16'h0001) begin
        next_cur.run = 1'b0;
        next_cur.flash_busy = 1'b0;
        next_cur.ee_busy = 1'b0;
        next_cur.halt = 1'b0;
        next_cur.erase_flash = 1'b0;
        next_cur.erase_ee = 1'b0;
        next_cur.fuse_wr = 1'b0;
        // page operations and buffer clear leave the buffer all ones
        next_cur.buf_clr = (cur.op_code >= nvm_cmd_pkg::CMD_PAGE_WRITE) &&
                           (cur.op_code <= nvm_cmd_pkg::CMD_BUF_CLEAR);
      end else begin
        next_cur.op_left = cur.op_left - 16'h0001;
      end
    end

    // command launch; unguarded or busy writes leave the register alone
    if (wr_acc && idx == nvm_cmd_pkg::IDX_CMD && guard_open && !busy_any) begin
      next_cur.cmd = I_PWDATA[2:0];
      next_cur.guard_cnt = 3'h0;
      next_cur.op_code = I_PWDATA[2:0];
      next_cur.wr_err = 1'b0;
      next_cur.to_ee = 1'b0;
      case (I_PWDATA[2:0])
        nvm_cmd_pkg::CMD_PAGE_WRITE, nvm_cmd_pkg::CMD_PAGE_ERASE, nvm_cmd_pkg::CMD_ERASE_WRITE: begin
          // mixed sections, boot target or guarded app code fail the command
          if (I_BUF_MIXED || I_TARGET_SECT == nvm_cmd_pkg::SECT_BOOT ||
              (I_TARGET_SECT == nvm_cmd_pkg::SECT_APPCODE && cur.app_guard)) begin
            next_cur.wr_err = 1'b1;
          end else if (I_TARGET_SECT == nvm_cmd_pkg::SECT_EEPROM) begin
            next_cur.run = 1'b1;
            next_cur.to_ee = 1'b1;
            next_cur.ee_busy = 1'b1;
            next_cur.op_left = EE_N;
          end else begin
            // flash page work stalls the cpu for its whole length
            next_cur.run = 1'b1;
            next_cur.flash_busy = 1'b1;
            next_cur.halt = 1'b1;
            next_cur.op_left = FLASH_N;
          end
        end
        nvm_cmd_pkg::CMD_BUF_CLEAR: begin
          next_cur.run = 1'b1;
          next_cur.halt = 1'b1;
          next_cur.op_left = nvm_cmd_pkg::BUF_CLEAR_CYCLES;
        end
        nvm_cmd_pkg::CMD_FULL_ERASE: begin
          // whole flash goes regardless of lock and guard bits
          next_cur.run = 1'b1;
          next_cur.halt = 1'b1;
          next_cur.erase_flash = 1'b1;
          next_cur.erase_ee = !I_EEPROM_KEEP_FUSE;
          next_cur.flash_busy = 1'b1;
          next_cur.ee_busy = !I_EEPROM_KEEP_FUSE;
          next_cur.op_left = FULL_N;
        end
        nvm_cmd_pkg::CMD_EE_ERASE: begin
          next_cur.run = 1'b1;
          next_cur.halt = 1'b1;
          next_cur.erase_ee = 1'b1;
          next_cur.ee_busy = 1'b1;
          next_cur.op_left = EE_ERASE_N;
        end
        nvm_cmd_pkg::CMD_FUSE_PROG: begin
          // cpu attempts never start; address and data registers feed the fuse
          if (I_PROG_PORT_ACCESS) begin
            next_cur.run = 1'b1;
            next_cur.fuse_wr = 1'b1;
            next_cur.flash_busy = 1'b1;
            next_cur.op_left = FUSE_N;
          end else begin
            next_cur.wr_err = 1'b1;
          end
        end
        default: ; // no action
      endcase
    end

    // ready flag: set wins over a same-cycle write-one clear
    if (wr_acc && idx == nvm_cmd_pkg::IDX_INTFLAG && I_PWDATA[nvm_cmd_pkg::BIT_EE_READY]) begin
      next_cur.ready_flag = 1'b0;
    end
    if (!cur.ee_busy) begin
      next_cur.ready_flag = 1'b1;
    end

    // sleep handshake: hold clocks while a write is still running
    case (cur.sleep)
      nvm_cmd_pkg::SL_RUN: begin
        if (I_SLEEP_REQ) begin
          next_cur.sleep = busy_any ? nvm_cmd_pkg::SL_HOLD : nvm_cmd_pkg::SL_SLEEP;
        end
      end
      nvm_cmd_pkg::SL_HOLD: begin
        if (!I_SLEEP_REQ) begin
          next_cur.sleep = nvm_cmd_pkg::SL_RUN;
          next_cur.buf_clr = 1'b1;
        end else if (!busy_any) begin
          next_cur.sleep = nvm_cmd_pkg::SL_SLEEP;
        end
      end
      nvm_cmd_pkg::SL_SLEEP: begin
        if (!I_SLEEP_REQ) begin
          next_cur.sleep = nvm_cmd_pkg::SL_RUN;
          next_cur.buf_clr = 1'b1;
        end
      end
      default: next_cur.sleep = nvm_cmd_pkg::SL_RUN;
    endcase
  end

  // ----------------------------------------------------------------
  // state register; reset stops any array operation at once
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      cur <= '0;
      cur.sleep <= nvm_cmd_pkg::SL_RUN;
      cur.cmd <= nvm_cmd_pkg::REG_RESET[2:0];
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign O_PRDATA = cur.prdata;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && cur.slverr;
  // array strobes drop with reset, which aborts a running write
  assign O_ARRAY_RUN = cur.run;
  assign O_ARRAY_CMD = cur.op_code;
  assign O_ARRAY_EEPROM = cur.to_ee;
  assign O_ERASE_FLASH_ALL = cur.erase_flash;
  assign O_ERASE_EEPROM_ALL = cur.erase_ee;
  assign O_FUSE_WRITE = cur.fuse_wr;
  // fuse read-back is an ordinary memory read outside this block
  assign O_FUSE_ADDR = cur.taddr;
  assign O_FUSE_DATA = cur.fdata;
  assign O_BUF_CLEAR = cur.buf_clr;
  assign O_CPU_HALT = cur.halt;
  assign O_BOOT_HIDE = cur.boot_lock;
  assign O_IRQ = cur.ready_flag && cur.ie;
  // only idle sleep keeps the wake path for this interrupt
  assign O_WAKE_REQ = O_IRQ && cur.sleep == nvm_cmd_pkg::SL_SLEEP &&
                      I_SLEEP_MODE == nvm_cmd_pkg::MODE_IDLE;
  assign O_NVM_ASLEEP = cur.sleep == nvm_cmd_pkg::SL_SLEEP;
  assign O_CLOCK_KEEP = cur.sleep == nvm_cmd_pkg::SL_HOLD;
endmodule // nvm_command_controller

/* File: sim/nvm_command_controller_asserts.sv */
// nvm_cmd_asserts: port-level checks of the command controller.
// assumes it is bound to the controller top, one clock domain.
`timescale 1ns/1ns
module nvm_cmd_asserts (
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [5:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic I_PROG_PORT_ACCESS,
  input wire logic I_GUARD_KEY_WRITE,
  input wire logic I_INSTR_STEP,
  input wire logic I_EXEC_IN_BOOT,
  input wire logic I_EEPROM_KEEP_FUSE,
  input wire logic I_SLEEP_REQ,
  input wire logic [1:0] I_SLEEP_MODE,
  input wire logic O_ARRAY_RUN,
  input wire logic [2:0] O_ARRAY_CMD,
  input wire logic O_ERASE_FLASH_ALL,
  input wire logic O_ERASE_EEPROM_ALL,
  input wire logic O_FUSE_WRITE,
  input wire logic O_BUF_CLEAR,
  input wire logic O_CPU_HALT,
  input wire logic O_BOOT_HIDE,
  input wire logic O_IRQ,
  input wire logic O_WAKE_REQ,
  input wire logic O_NVM_ASLEEP,
  input wire logic O_CLOCK_KEEP
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  logic [3:0] age;
  logic cmd_wr;
  // ----------------------------------------
  // unlock window helper
  // ----------------------------------------
  // instructions since the last key; saturates so it never wraps open
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      age <= 4'hf;
    end else if (I_GUARD_KEY_WRITE) begin
      age <= 4'h0;
    end else if (I_INSTR_STEP && age != 4'hf) begin
      age <= age + 4'h1;
    end
  end
  assign cmd_wr = I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 6'h00;
  sequence s_clr_run;
    O_ARRAY_RUN [*7] ##1 !O_ARRAY_RUN;
  endsequence
  property p_guard;
    cmd_wr && age >= 4'h4 |=> !$rose(O_ARRAY_RUN);
  endproperty
  a_guard: assert property (p_guard) else $error("command taken without key");
  property p_fuse_cpu;
    cmd_wr && I_PWDATA[2:0] == 3'h7 && !I_PROG_PORT_ACCESS && !O_FUSE_WRITE |=> !O_FUSE_WRITE;
  endproperty
  a_fuse_cpu: assert property (p_fuse_cpu) else $error("cpu started fuse write");
  property p_bufclr;
    $rose(O_ARRAY_RUN) && O_ARRAY_CMD == 3'h4 |-> s_clr_run;
  endproperty
  a_bufclr: assert property (p_bufclr) else $error("buffer clear length wrong");
  property p_chip;
    $rose(O_ERASE_FLASH_ALL) |-> O_ERASE_EEPROM_ALL == !I_EEPROM_KEEP_FUSE;
  endproperty
  a_chip: assert property (p_chip) else $error("chip erase eeprom choice wrong");
  property p_eehalt;
    O_ERASE_EEPROM_ALL && !O_ERASE_FLASH_ALL |-> O_CPU_HALT;
  endproperty
  a_eehalt: assert property (p_eehalt) else $error("cpu runs during eeprom erase");
  property p_keep;
    $rose(I_SLEEP_REQ) && O_ARRAY_RUN |=> O_CLOCK_KEEP && !O_NVM_ASLEEP;
  endproperty
  a_keep: assert property (p_keep) else $error("slept during write");
  property p_wake_clr;
    $fell(I_SLEEP_REQ) && O_NVM_ASLEEP |=> O_BUF_CLEAR && !O_NVM_ASLEEP;
  endproperty
  a_wake_clr: assert property (p_wake_clr) else $error("no buffer clear on wake");
  property p_wake;
    O_WAKE_REQ |-> O_IRQ && O_NVM_ASLEEP && I_SLEEP_MODE == 2'h0;
  endproperty
  a_wake: assert property (p_wake) else $error("wake outside idle sleep");
  property p_hide;
    $rose(O_BOOT_HIDE) |-> !$past(I_EXEC_IN_BOOT);
  endproperty
  a_hide: assert property (p_hide) else $error("boot hidden while inside it");
endmodule // nvm_cmd_asserts
bind nvm_command_controller nvm_cmd_asserts u_chk (.I_REF_CLK(I_REF_CLK), .I_SYS_RST(I_SYS_RST),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
  .I_PROG_PORT_ACCESS(I_PROG_PORT_ACCESS), .I_GUARD_KEY_WRITE(I_GUARD_KEY_WRITE),
  .I_INSTR_STEP(I_INSTR_STEP), .I_EXEC_IN_BOOT(I_EXEC_IN_BOOT), .I_EEPROM_KEEP_FUSE(I_EEPROM_KEEP_FUSE),
  .I_SLEEP_REQ(I_SLEEP_REQ), .I_SLEEP_MODE(I_SLEEP_MODE), .O_ARRAY_RUN(O_ARRAY_RUN),
  .O_ARRAY_CMD(O_ARRAY_CMD), .O_ERASE_FLASH_ALL(O_ERASE_FLASH_ALL), .O_ERASE_EEPROM_ALL(O_ERASE_EEPROM_ALL),
  .O_FUSE_WRITE(O_FUSE_WRITE), .O_BUF_CLEAR(O_BUF_CLEAR), .O_CPU_HALT(O_CPU_HALT), .O_BOOT_HIDE(O_BOOT_HIDE),
  .O_IRQ(O_IRQ), .O_WAKE_REQ(O_WAKE_REQ), .O_NVM_ASLEEP(O_NVM_ASLEEP), .O_CLOCK_KEEP(O_CLOCK_KEEP));

/* File: sim/nvm_command_controller_tb.sv */
// nvm_command_controller_tb: apb register and command sequences.
// assumes short operation parameters; the apb answer is awaited on pready.
`timescale 1ns/1ns
module nvm_command_controller_tb;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, port = 0, key, step, unl = 0, boot = 0, mix = 0, bld = 0;
  logic keep = 1, slp = 0, pready, pslverr, run, aee, efl, eee, fw, bclr, halt, hide, irq, wake, asl, ck;
  logic [5:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [1:0] sect = 1, mode = 0;
  logic [2:0] acmd;
  logic [15:0] fa, fd, bla = 16'h0000;
  int err_count = 0, num_checks = 0, n;
  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  nvm_command_controller #(.FLASH_OP_CYCLES(12), .EE_OP_CYCLES(12), .EE_ERASE_CYCLES(16),
    .FULL_ERASE_CYCLES(16), .FUSE_CYCLES(8)) dut (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_PROG_PORT_ACCESS(port), .I_GUARD_KEY_WRITE(key),
    .I_INSTR_STEP(step), .I_EXEC_IN_BOOT(boot), .I_TARGET_SECT(sect), .I_BUF_MIXED(mix),
    .I_BUF_LOAD(bld), .I_BUF_LOAD_ADDR(bla), .I_EEPROM_KEEP_FUSE(keep), .I_SLEEP_REQ(slp),
    .I_SLEEP_MODE(mode), .O_ARRAY_RUN(run), .O_ARRAY_CMD(acmd), .O_ARRAY_EEPROM(aee), .O_ERASE_FLASH_ALL(efl),
    .O_ERASE_EEPROM_ALL(eee), .O_FUSE_WRITE(fw), .O_FUSE_ADDR(fa), .O_FUSE_DATA(fd), .O_BUF_CLEAR(bclr),
    .O_CPU_HALT(halt), .O_BOOT_HIDE(hide), .O_IRQ(irq), .O_WAKE_REQ(wake), .O_NVM_ASLEEP(asl),
    .O_CLOCK_KEEP(ck));
  nvm_cpu_model cpu (.i_clk(clk), .i_rst(rst), .i_unlock(unl), .o_key(key), .o_step(step));
  initial forever #2 clk = ~clk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // request held until the edge that samples pready; the answer is taken at that edge
  task automatic apb(input logic w, input logic [3:0] idx, input logic [31:0] d, output logic [1:0] e);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = {1'b0, pslverr};
    psel <= 0;
    pen <= 0;
    // return mid-cycle so callers see outputs settled after the access edge
    @(negedge clk);
  endtask
  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    logic [1:0] e;
    apb(1, idx, d, e);
  endtask
  task automatic rd(input logic [3:0] idx, input logic [31:0] x);
    logic [1:0] e;
    apb(0, idx, 0, e);
    chk(r, x);
    chk(e, 0);
  endtask
  task automatic cmd(input logic [2:0] c);
    @(posedge clk);
    unl <= 1;
    @(posedge clk);
    unl <= 0;
    wr(nvm_cmd_pkg::IDX_CMD, c);
  endtask
  task automatic idle;
    while (run === 1'b1 || fw === 1'b1) @(negedge clk);
  endtask
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict;
  end
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  initial begin
    logic [1:0] e;
    repeat (3) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 4; i++) rd(4'(i), 0); // reset values
    rd(nvm_cmd_pkg::IDX_INTFLAG, 1);
    apb(0, 4'h5, 0, e);
    chk(r, 0); // unmapped
    chk(e, 1); // unmapped
    wr(nvm_cmd_pkg::IDX_CMD, 4);
    rd(nvm_cmd_pkg::IDX_CMD, 0);
    cmd(4);
    for (n = 0; run === 1'b1; n++) @(negedge clk);
    chk(n, 7);
    cmd(1);
    rd(nvm_cmd_pkg::IDX_STATUS, 1);
    @(posedge clk) slp <= 1;
    repeat (2) @(negedge clk);
    chk({ck, asl}, 2);
    idle;
    repeat (2) @(negedge clk);
    chk(asl, 1);
    @(posedge clk);
    slp <= 0;
    @(posedge clk);
    @(negedge clk);
    chk(bclr, 1);
    @(posedge clk) sect <= 2;
    for (int c = 1; c < 4; c++) begin
      cmd(3'(c));
      chk({run, acmd}, 8 + c);
      idle;
    end
    // writes to mixed sections in the buffer must fail the page write
    @(posedge clk) mix <= 1;
    cmd(1);
    chk(run, 0);
    rd(nvm_cmd_pkg::IDX_STATUS, 4);
    @(posedge clk) mix <= 0;
    // a buffer load moves the address register to that location
    @(posedge clk) bld <= 1;
    bla <= 16'h00c3;
    @(posedge clk) bld <= 0;
    rd(nvm_cmd_pkg::IDX_ADDR, 32'h0000_00c3);
    wr(nvm_cmd_pkg::IDX_LOCK, 1);
    wr(nvm_cmd_pkg::IDX_LOCK, 0);
    rd(nvm_cmd_pkg::IDX_LOCK, 1);
    @(posedge clk) sect <= 1;
    cmd(1);
    chk(run, 0);
    rd(nvm_cmd_pkg::IDX_STATUS, 4);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) keep <= ~keep;
      cmd(5);
      chk({efl, eee}, 32'(3 - k));
      idle;
    end
    cmd(6);
    chk({halt, eee}, 3);
    idle;
    wr(nvm_cmd_pkg::IDX_INTEN, 1);
    chk(irq, 1);
    @(posedge clk) sect <= 3;
    cmd(1);
    chk(aee, 1);
    wr(nvm_cmd_pkg::IDX_INTFLAG, 1);
    rd(nvm_cmd_pkg::IDX_INTFLAG, 0);
    chk(irq, 0);
    idle;
    repeat (2) @(negedge clk);
    chk(irq, 1);
    @(posedge clk);
    slp <= 1;
    repeat (2) @(negedge clk);
    chk(wake, 1);
    @(posedge clk) mode <= 2;
    @(negedge clk);
    chk(wake, 0);
    @(posedge clk) slp <= 0;
    cmd(7);
    chk(fw, 0);
    rd(nvm_cmd_pkg::IDX_STATUS, 4);
    @(posedge clk) port <= 1;
    wr(nvm_cmd_pkg::IDX_ADDR, 32'h0000_1234);
    wr(nvm_cmd_pkg::IDX_DATA, 32'h0000_abcd);
    cmd(7);
    chk(fw, 1);
    chk({fa, fd}, 32'h1234_abcd);
    idle;
    @(posedge clk) port <= 0;
    wr(nvm_cmd_pkg::IDX_LOCK, 2);
    rd(nvm_cmd_pkg::IDX_LOCK, 1);
    @(posedge clk) boot <= 1;
    wr(nvm_cmd_pkg::IDX_LOCK, 2);
    rd(nvm_cmd_pkg::IDX_LOCK, 3);
    chk(hide, 0);
    @(posedge clk) boot <= 0;
    repeat (3) @(negedge clk);
    chk(hide, 1);
    @(posedge clk) sect <= 2;
    cmd(1);
    chk(run, 1);
    @(posedge clk) rst <= 1;
    @(negedge clk);
    chk(run, 0);
    @(posedge clk) rst <= 0;
    rd(nvm_cmd_pkg::IDX_LOCK, 0);
    give_verdict;
  end
endmodule // nvm_command_controller_tb

/* File: sim/nvm_cpu_model.sv */
// nvm_cpu_model: cpu core seen from the controller, retiring
// one instruction every fourth clock and writing the unlock key
// when the bench asks for it.
`timescale 1ns/1ns
module nvm_cpu_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_unlock,
  output logic o_key,
  output logic o_step
);
  logic [1:0] div;
  // key lands one clock after the request, steps keep running
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div <= 2'h0;
      o_step <= 1'b0;
      o_key <= 1'b0;
    end else begin
      div <= div + 2'h1;
      o_step <= (div == 2'h3);
      o_key <= i_unlock;
    end
  end
endmodule // nvm_cpu_model
